// file: rtl/scp_clock_prescaler.v
// Summary of operation
// - System clock divides by even 4..1020, or 2..510 in double speed.
// - Eight-bit up-counter reloads from reload register when it overflows.
// - Reload FFH disables the prescaler; only clear double speed divides, by two.
// - Frequency is osc times 2^x2 over 4(255-reload), or over 2 at 255.
// - Each overflow toggles the system clock; two overflows per period.
// - Divided clock feeds CPU and peripherals; peripheral base equals CPU.
// - Reload writes allowed anytime; effective at next overflow, 510 cycles max.
// - Reset loads reload register with all ones, disabling the prescaler.
// - Timer prescaler: 4-bit down-counter reloading at zero; ratio 1..16.
// - Prescale field resets to 5; register reads 0101 in upper nibble.
// - One timer prescaler paces timers 0-2, counter array and watchdog.
// - Compatibility: prescaler always runs; select bit adds divide-by-two.
// - Fast mode: set select bit enables prescaler; clear gives CPU clock.
// - Compatibility: other peripherals choose CPU clock or CPU clock divided by two.
// - Default timer rate: every CPU cycle in fast, every sixth otherwise.
// - Select register: seven select bits over double speed; resets zero.
// - Double speed clear halves oscillator first; set passes it undivided.
// - Double speed: 12 or 6 per machine cycle, 2 or 1 when fast.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`include "scp_defines.vh"
module scp_clock_prescaler (
    input wire core_clk_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    output wire sys_clk_out,
    output wire cpu_clk_en_out,
    output wire machine_cycle_en_out,
    output wire timer_prescale_en_out,
    output wire [6:0] periph_clk_en_out,
    output wire double_speed_out,
    output wire fast_mode_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    reg [6:0] clock_sel;
    reg double_speed_bit;
    reg [7:0] system_clock_reload;
    reg [3:0] timer_prescale_field;
    reg fast_mode;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler state.

    reg osc_div;
    reg [7:0] sc_count;
    reg [7:0] active_reload;
    reg active_x2;
    reg sys_clk;
    reg [3:0] tps_count;
    reg [2:0] mc_count;

    wire sc_tick;
    wire sc_off;
    wire sc_hit;
    wire cpu_en;
    wire tps_en;
    wire bus_access;
    wire bus_write;
    wire bus_setup_read;
    wire hit_pcs;
    wire hit_scr;
    wire hit_tpc;
    wire hit_mode;
    wire hit_any;
    reg [7:0] read_value;

    // True when the APB word address selects the given register index.
    function addr_hit;
        input [11:0] addr;
        input [7:0] idx;
        begin
            addr_hit = (addr[11:2] == {2'b00, idx});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave. Zero wait states; read data is captured in the setup
    // cycle so that it comes from a flip-flop during the access cycle.

    assign hit_pcs = addr_hit(paddr_in, `SCP_IDX_PCS);
    assign hit_scr = addr_hit(paddr_in, `SCP_IDX_SCR);
    assign hit_tpc = addr_hit(paddr_in, `SCP_IDX_TPC);
    assign hit_mode = addr_hit(paddr_in, `SCP_IDX_MODE);
    assign hit_any = hit_pcs | hit_scr | hit_tpc | hit_mode;

    assign bus_access = psel_in & penable_in;
    assign bus_write = bus_access & pwrite_in & hit_any;
    assign bus_setup_read = psel_in & ~penable_in & ~pwrite_in;
    assign pready_out = 1'b1;
    assign pslverr_out = bus_access & ~hit_any;

    always @* begin
        read_value = 8'h00;
        if (hit_pcs) begin
            read_value = {clock_sel, double_speed_bit};
        end else if (hit_scr) begin
            read_value = system_clock_reload;
        end else if (hit_tpc) begin
            read_value = {timer_prescale_field, 4'h0};
        end else if (hit_mode) begin
            read_value[`SCP_FAST_BIT] = fast_mode;
            read_value[`SCP_ACT_BIT] = (active_reload != `SCP_RELOAD_OFF);
            read_value[`SCP_SCLK_BIT] = sys_clk;
            read_value[`SCP_CNT_MSB:`SCP_CNT_LSB] = tps_count;
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (bus_setup_read) begin
            prdata_out <= {24'h00_0000, read_value};
        end
    end

    // Writes land at any time; the counters pick them up later.
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_sel <= `SCP_PCS_RST;
            double_speed_bit <= `SCP_X2_RST;
            system_clock_reload <= `SCP_SCR_RST;
            timer_prescale_field <= `SCP_TPS_RST;
            fast_mode <= `SCP_FAST_RST;
        end else if (bus_write) begin
            if (hit_pcs) begin
                clock_sel <= pwdata_in[`SCP_SEL_MSB:`SCP_SEL_LSB];
                double_speed_bit <= pwdata_in[`SCP_X2_BIT];
            end else if (hit_scr) begin
                system_clock_reload <= pwdata_in[7:0];
            end else if (hit_tpc) begin
                timer_prescale_field <= pwdata_in[`SCP_TPS_MSB:`SCP_TPS_LSB];
            end else if (hit_mode) begin
                fast_mode <= pwdata_in[`SCP_FAST_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator pre-divider. The counter ticks every cycle in double
    // speed and every second cycle otherwise, so that without double
    // speed the system clock is half the oscillator rate at 50% duty.

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            osc_div <= 1'b0;
        end else begin
            osc_div <= ~osc_div;
        end
    end

    assign sc_tick = active_x2 | osc_div;

    ////////////////////////////////////////////////////////////////////////
    // System clock prescaler. The step from FFH to 00H is taken in the
    // same tick that the count arrives at FFH, so 255 minus the reload
    // ticks pass between two overflows. With the prescaler off the
    // system clock runs at the tick rate; the level then toggles every
    // cycle, which in double speed shows only half the true rate, so
    // users must take the CPU enable, not the level, as the clock.

    assign sc_off = (active_reload == `SCP_RELOAD_OFF);
    assign sc_hit = sc_off | (sc_count == `SCP_CNT_WRAP);

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sc_count <= `SCP_SCR_RST;
            active_reload <= `SCP_SCR_RST;
            active_x2 <= `SCP_X2_RST;
            sys_clk <= 1'b0;
        end else begin
            if (sc_tick && sc_hit) begin
                sc_count <= system_clock_reload;
                active_reload <= system_clock_reload;
                active_x2 <= double_speed_bit;
            end else if (sc_tick) begin
                sc_count <= sc_count + 8'h01;
            end
            if (sc_off || (sc_tick && sc_hit)) begin
                sys_clk <= ~sys_clk;
            end
        end
    end

    // One CPU clock per system clock period, on its rising edge, and one
    // per tick while the prescaler is off.
    assign cpu_en = sc_tick & (sc_off | (sc_hit & ~sys_clk));

    ////////////////////////////////////////////////////////////////////////
    // Shared timer prescaler: down-counter paced by the CPU clock.

    assign tps_en = cpu_en & (tps_count == 4'h0);

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tps_count <= 4'h0;
        end else if (cpu_en) begin
            if (tps_count == 4'h0) begin
                tps_count <= timer_prescale_field;
            end else begin
                tps_count <= tps_count - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine cycle: six CPU clocks in compatibility mode (12 or 6
    // oscillator periods by the double-speed bit), one in fast mode.

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mc_count <= 3'h0;
        end else if (cpu_en) begin
            if (fast_mode || mc_count == `SCP_MC_LAST) begin
                mc_count <= 3'h0;
            end else begin
                mc_count <= mc_count + 3'h1;
            end
        end
    end

    assign machine_cycle_en_out = cpu_en
                                & (fast_mode | (mc_count == `SCP_MC_LAST));

    ////////////////////////////////////////////////////////////////////////
    // Per-peripheral clock enables; bit order follows the select field.

    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_periph
            scp_periph_div #(
                .USES_TPS(`SCP_TPS_USERS >> i & 1)
            ) u_div (
                .core_clk_in(core_clk_in),
                .nrst_in(nrst_in),
                .cpu_en_in(cpu_en),
                .tps_en_in(tps_en),
                .sel_in(clock_sel[i]),
                .fast_mode_in(fast_mode),
                .clk_en_out(periph_clk_en_out[i])
            );
        end
    endgenerate

    assign sys_clk_out = sys_clk;
    assign cpu_clk_en_out = cpu_en;
    assign timer_prescale_en_out = tps_en;
    assign double_speed_out = double_speed_bit;
    assign fast_mode_out = fast_mode;

endmodule

// file: rtl/scp_defines.vh
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// Register indices; the APB byte address is four times the index.
`define SCP_IDX_PCS 8'h8f
`define SCP_IDX_SCR 8'h97
`define SCP_IDX_TPC 8'hae
`define SCP_IDX_MODE 8'hb1

// Reset values.
`define SCP_PCS_RST 7'h00
`define SCP_X2_RST 1'b0
`define SCP_SCR_RST 8'hff
`define SCP_TPS_RST 4'h5
`define SCP_FAST_RST 1'b0

// Field positions.
`define SCP_X2_BIT 0
`define SCP_SEL_MSB 7
`define SCP_SEL_LSB 1
`define SCP_TPS_MSB 7
`define SCP_TPS_LSB 4
`define SCP_FAST_BIT 0
`define SCP_ACT_BIT 1
`define SCP_SCLK_BIT 2
`define SCP_CNT_MSB 7
`define SCP_CNT_LSB 4

// Reload value that turns the system clock prescaler off.
`define SCP_RELOAD_OFF 8'hff
// Counter value whose next increment reaches the overflow point.
`define SCP_CNT_WRAP 8'hfe
// Last CPU clock of a compatibility machine cycle (six CPU clocks).
`define SCP_MC_LAST 3'h5
// Peripherals fed by the timer prescaler: timers 0-2, counter array,
// watchdog. Bit order: t0, t1, t2, serial, array, watchdog, two-wire.
`define SCP_TPS_USERS 7'b0110111

`endif

// file: rtl/scp_periph_div.v
`timescale 1ns/1ns
module scp_periph_div #(
    parameter USES_TPS = 1
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire cpu_en_in,
    input wire tps_en_in,
    input wire sel_in,
    input wire fast_mode_in,
    output wire clk_en_out
);

    wire src_en;
    reg half;

    assign src_en = (USES_TPS != 0) ? tps_en_in : cpu_en_in;

    // Extra divide-by-two stage used in compatibility mode.
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            half <= 1'b0;
        end else if (src_en) begin
            half <= ~half;
        end
    end

    // Fast mode: the select bit switches the timer prescaler in or out.
    assign clk_en_out = fast_mode_in ? (sel_in ? tps_en_in : cpu_en_in)
                      : (sel_in ? (src_en & half) : src_en);

endmodule

// file: verification/scp_checker.sv
`timescale 1ns/1ns
`include "scp_defines.vh"
module scp_checker (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sys_clk_out,
    input wire logic cpu_clk_en_out,
    input wire logic machine_cycle_en_out,
    input wire logic timer_prescale_en_out,
    input wire logic [6:0] periph_clk_en_out
);
    logic acc;
    logic mapped;
    assign acc = psel_in && penable_in;
    assign mapped = paddr_in[11:10] == 2'b00 && paddr_in[9:2] inside
        {`SCP_IDX_PCS, `SCP_IDX_SCR, `SCP_IDX_TPC, `SCP_IDX_MODE};

    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_pulse;
        cpu_clk_en_out;
    endsequence
    sequence s_next;
        ##[1:1020] cpu_clk_en_out;
    endsequence
    sequence s_rise;
        ##[0:1] $rose(sys_clk_out);
    endsequence
    sequence s_edge;
        $changed(sys_clk_out);
    endsequence
    sequence s_next_edge;
        ##[1:510] $changed(sys_clk_out);
    endsequence

    a_ready_high: assert property (pready_out)
        else $error("pready low");
    a_err_decode: assert property (pslverr_out == (acc && !mapped))
        else $error("slave error decode wrong");
    a_rdata_upper: assert property (prdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_cpu_spacing: assert property (s_pulse |-> s_next)
        else $error("cpu pulse gap too long");
    a_cpu_on_rise: assert property (s_pulse |-> s_rise)
        else $error("cpu pulse not at system clock rise");
    a_sys_half_max: assert property (s_edge |-> s_next_edge)
        else $error("system clock half period too long");
    a_mc_in_cpu: assert property (machine_cycle_en_out |-> s_pulse)
        else $error("machine cycle pulse outside cpu pulse");
    a_tps_in_cpu: assert property (timer_prescale_en_out |-> s_pulse)
        else $error("timer prescale pulse outside cpu pulse");
    a_periph_in_cpu: assert property (|periph_clk_en_out |-> s_pulse)
        else $error("peripheral pulse outside cpu pulse");
endmodule

bind scp_clock_prescaler scp_checker scp_checker_i (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sys_clk_out(sys_clk_out), .cpu_clk_en_out(cpu_clk_en_out),
    .machine_cycle_en_out(machine_cycle_en_out),
    .timer_prescale_en_out(timer_prescale_en_out),
    .periph_clk_en_out(periph_clk_en_out)
);

// file: verification/scp_tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic prdy, perr, sclk, cpu, mc, tpe, x2, fast, er;
    logic [6:0] per;
    int n_mismatch = 0;
    int checks = 0;
    int c;

    always #50 clk = ~clk;

    scp_clock_prescaler scp_clock_prescaler_i (
        .core_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .sys_clk_out(sclk), .cpu_clk_en_out(cpu),
        .machine_cycle_en_out(mc), .timer_prescale_en_out(tpe),
        .periph_clk_en_out(per), .double_speed_out(x2),
        .fast_mode_out(fast)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) begin
            @(posedge clk);
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    function logic pk(int s);
        case (s)
            0: return cpu;
            1: return mc;
            2: return tpe;
            default: return per[s-3];
        endcase
    endfunction

    // Cycles from one pulse of the chosen output to the next.
    task period(input int s, output int p);
        int n;
        n = 0;
        p = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pk(s) !== 1'b1 && n < 9000);
        do begin
            @(posedge clk);
            p++;
        end while (pk(s) !== 1'b1 && p < 9000);
    endtask

    function int exp_rate(int b, int f, int t, int s);
        if (f != 0)
            return s ? t + 1 : 1;
        if (b == 3 || b == 6)
            return s ? 2 : 1;
        return (t + 1) * (s ? 2 : 1);
    endfunction

    task t_reset;
        logic [11:0] ra[4] = '{12'h23c, 12'h25c, 12'h2b8, 12'h300};
        logic [7:0] rv[4] = '{8'h00, 8'hff, 8'h50, 8'h00};
        apb(1'b1, 12'h300, 8'h55);
        chk(er, 1'b1);
        apb(1'b1, 12'h2c4, 8'hfe);
        apb(1'b0, 12'h2c4, 8'h00);
        chk(rd[1:0], 2'b00);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 8'h00);
            chk(rd, {24'h0, rv[i]});
            chk(er, i == 3);
        end
        chk({x2, fast}, 2'b00);
        period(0, c);
        chk(c, 2);
        period(1, c);
        chk(c, 12);
        period(2, c);
        chk(c, 12);
    endtask

    task t_clk;
        logic [7:0] rl[6] = '{8'hff, 8'hff, 8'hfd, 8'hfd, 8'h00, 8'h00};
        int ep[6] = '{2, 1, 8, 4, 1020, 510};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h23c, {7'h0, i[0]});
            apb(1'b1, 12'h25c, rl[i]);
            period(0, c);
            period(0, c);
            chk(c, ep[i]);
            if (rl[i] != 8'hff) begin
                @(posedge clk);
                chk(sclk, 1'b1);
            end
        end
        apb(1'b0, 12'h2c4, 8'h00);
        chk(rd[1], 1'b1);
    endtask

    task t_periph;
        int tv;
        apb(1'b1, 12'h25c, 8'hff);
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 4; k++) begin
                tv = k[1] ? 15 : 0;
                apb(1'b1, 12'h2c4, {7'h0, f[0]});
                apb(1'b1, 12'h2b8, {tv[3:0], 4'h0});
                apb(1'b1, 12'h23c, {{7{k[0]}}, 1'b1});
                chk(fast, f[0]);
                period(1, c);
                period(1, c);
                chk(c, f ? 1 : 6);
                period(2, c);
                period(2, c);
                if (f == 0)
                    chk(c, tv + 1);
                for (int b = 3; b < 10; b++) begin
                    period(b, c);
                    period(b, c);
                    chk(c, exp_rate(b - 3, f, tv, k[0]));
                end
            end
        end
    endtask

    task stop_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #5_000_000;
        n_mismatch++;
        $display("FAIL %0t timeout", $time);
        stop_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_clk;
        t_periph;
        stop_test;
    end
endmodule
